/* tb/hthr_line_model.sv */
// line model: converter codes for loop current and line voltage
// assumes the bench sets the commanded levels
`timescale 1ns/1ps
`default_nettype none
module hthr_line_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] cur_set_i,
  input  wire logic [7:0] volt_set_i,
  output logic      [7:0] cur_o,
  output logic      [7:0] volt_o
);
  // codes follow commanded levels, volts signed
  always_ff @(posedge clk_i) begin
    cur_o  <= cur_set_i;
    volt_o <= volt_set_i;
  end
endmodule
`default_nettype wire

/* tb/hthr_top_bench.sv */
// bench for the hook timing and threshold slice
// assumes a short tick of 10 cycles and the line model beside it
`timescale 1ns/1ps
`default_nettype none
module hthr_top_bench;
  logic        clk_i, rst_i, cyc, stb, we, ack, settled, rel, pole, irq, close;
  logic [9:0]  adr;
  logic [7:0]  wd, rd, cur, volt, lcur, lvolt;
  logic [31:0] dat_o;
  int          bad_count = 0, check_count = 0, n;
  // rows: write flag, index, write data, expected read
  logic [24:0] tbl [8] = '{{1'b0, 8'h1f, 8'h00, 8'h20}, {1'b0, 8'h2b, 8'h00, 8'h00},
    {1'b1, 8'h1f, 8'hff, 8'h00}, {1'b0, 8'h1f, 8'h00, 8'h6b}, {1'b1, 8'h20, 8'hff, 8'h00},
    {1'b0, 8'h20, 8'h00, 8'h00}, {1'b1, 8'h2b, 8'ha5, 8'h00}, {1'b0, 8'h2b, 8'h00, 8'ha5}};
  // clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  hthr_top #(.TICK_CYC(10)) hthr_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i({24'h0, wd}),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .loop_current_raw_i(lcur), .line_voltage_raw_i(lvolt),
    .hook_close_o(close), .offhook_settled_o(settled), .onhook_release_o(rel),
    .rx_pole_sel_o(pole), .irq_o(irq));
  hthr_line_model hthr_line_model_i (.clk_i(clk_i), .cur_set_i(cur), .volt_set_i(volt),
    .cur_o(lcur), .volt_o(lvolt));
  task automatic end_of_test;
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack under a bound
  task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wd <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin
      bad_count++;
      end_of_test();
    end
    @(posedge clk_i);
  endtask
  // counts edges until settled rises or release falls
  task automatic waitfor(input logic r, output int m);
    m = 0;
    while ((r ? rel !== 1'b0 : settled !== 1'b1) && m < 2000) begin
      @(posedge clk_i);
      m++;
    end
    if (m >= 2000) begin
      bad_count++;
      end_of_test();
    end
  endtask
  // main sequence
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wd, cur} = '0;
    volt = 8'h02;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({7'h0, irq}, 8'h00);
    foreach (tbl[i]) begin
      bus(tbl[i][24], tbl[i][23:16], tbl[i][15:8]);
      if (!tbl[i][24]) chk(rd, tbl[i][7:0]);
    end
    chk({7'h0, pole}, 8'h01);
    bus(1'b0, 8'h1d, 8'h00);
    chk(rd, 8'h02);
    bus(1'b1, 8'h1f, 8'h68);
    bus(1'b0, 8'h1d, 8'h00);
    chk(rd, 8'h00);
    bus(1'b1, 8'h2b, 8'h0a);
    bus(1'b1, 8'h2d, 8'h04);
    bus(1'b1, 8'h2c, 8'h07);
    volt <= 8'hec;
    repeat (8) @(posedge clk_i);
    bus(1'b0, 8'h2c, 8'h00);
    chk(rd, 8'h0f);
    chk({7'h0, irq}, 8'h01);
    bus(1'b1, 8'h2c, 8'h06);
    bus(1'b0, 8'h2c, 8'h00);
    chk(rd, 8'h06);
    chk({7'h0, irq}, 8'h00);
    volt <= 8'h05;
    repeat (8) @(posedge clk_i);
    bus(1'b0, 8'h2c, 8'h00);
    chk(rd, 8'h0e);
    bus(1'b1, 8'h2d, 8'h05);
    waitfor(1'b0, n);
    chk({7'h0, n >= 798 && n <= 806}, 8'h01);
    bus(1'b1, 8'h2d, 8'h04);
    @(posedge clk_i);
    chk({7'h0, rel}, 8'h01);
    chk({7'h0, close}, 8'h01);
    waitfor(1'b1, n);
    chk({7'h0, n >= 295 && n <= 305}, 8'h01);
    @(posedge clk_i);
    chk({7'h0, close}, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire

/* verilog/hthr_if.sv */
// threshold carrier between the register slice and the comparator
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface hthr_if;
  logic [7:0] threshold;
  logic       src_sel;
  logic       polarity;
  logic       force_dis;
  logic [7:0] line_voltage;
  logic [7:0] loop_current;
  logic       cross_evt;
  logic       rev_evt;
  modport thr (input threshold, src_sel, polarity, force_dis,
               output line_voltage, loop_current, cross_evt, rev_evt);
  modport ctl (output threshold, src_sel, polarity, force_dis,
               input line_voltage, loop_current, cross_evt, rev_evt);
endinterface
`default_nettype wire

/* verilog/hthr_pkg.sv */
// hook timing and threshold register slice: shared constants and decoders
// assumes a 200 MHz clock and a word-aligned wishbone register window
package hthr_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_LOOP_CUR  = 8'h1c;
  localparam logic [7:0] IDX_LINE_VOLT = 8'h1d;
  localparam logic [7:0] IDX_CTRL4     = 8'h1f;
  localparam logic [7:0] IDX_RSVD_LO   = 8'h20;
  localparam logic [7:0] IDX_RSVD_HI   = 8'h2a;
  localparam logic [7:0] IDX_THRESH    = 8'h2b;
  localparam logic [7:0] IDX_THR_CTRL  = 8'h2c;
  localparam logic [7:0] IDX_AUX       = 8'h2d;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h2e;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h2f;
  localparam int         WB_ADR_W      = 10;

  // hook_timing_filter_control fields
  localparam int         CTRL4_FOH_LSB = 5;
  localparam int         CTRL4_ONHOOK_SPEED_EXT    = 3;
  localparam int         CTRL4_RX_POLE_SEL    = 1;
  localparam int         CTRL4_LINE_VOLT_FORCE_DISABLE    = 0;
  localparam logic [7:0] CTRL4_WMASK   = 8'h6b;
  localparam logic [7:0] CTRL4_RST     = 8'h20;
  // threshold control fields
  localparam int         THR_CVI       = 3;
  localparam int         THR_CVS       = 2;
  localparam int         THR_CVM       = 1;
  localparam int         THR_CVP       = 0;
  localparam logic [7:0] THR_WMASK     = 8'h07;
  localparam logic [7:0] THR_CTRL_RST  = 8'h00;
  localparam logic [7:0] THRESH_RST    = 8'h00;
  // auxiliary control fields
  localparam int         AUX_OH        = 0;
  localparam int         AUX_OHS       = 1;
  localparam int         AUX_GLOBAL_IRQ_ENABLE      = 2;
  localparam int         AUX_SQ_LSB    = 4;
  localparam logic [7:0] AUX_WMASK     = 8'h37;
  localparam logic [7:0] AUX_RST       = 8'h00;
  // interrupt status bits
  localparam int         NEVT          = 4;
  localparam int         EVT_CROSS     = 0;
  localparam int         EVT_SETTLED   = 1;
  localparam int         EVT_ONHOOK    = 2;
  localparam int         EVT_REV       = 3;
  localparam logic [3:0] IRQ_RST       = 4'h0;

  // timing: one tick is 100 us
  localparam int CLK_MHZ      = 200;
  localparam int TICK_US      = 100;
  localparam int TICK_CYC     = CLK_MHZ * TICK_US;
  localparam int CNT_W        = 13;
  localparam int OH_A_MS      = 512;
  localparam int OH_B_MS      = 128;
  localparam int OH_C_MS      = 64;
  localparam int OH_D_MS      = 8;
  localparam int ONHOOK_E_MS  = 3;
  localparam int ONHOOK_S_MS  = 26;
  localparam int LV_FORCE_V   = 3;

  // off-hook counter length in ticks for a selection code
  function automatic logic [CNT_W-1:0] foh_ticks(input logic [1:0] sel);
    unique case (sel)
      2'b00: foh_ticks = CNT_W'(OH_A_MS * 1000 / TICK_US);
      2'b01: foh_ticks = CNT_W'(OH_B_MS * 1000 / TICK_US);
      2'b10: foh_ticks = CNT_W'(OH_C_MS * 1000 / TICK_US);
      2'b11: foh_ticks = CNT_W'(OH_D_MS * 1000 / TICK_US);
    endcase
  endfunction

  // on-hook ramp length in ticks, zero means release at once
  function automatic logic [CNT_W-1:0] onhook_ticks(input logic base, input logic ext,
                                                   input logic [1:0] sq);
    if (base && (sq == 2'b11)) onhook_ticks = CNT_W'(ONHOOK_S_MS * 1000 / TICK_US);
    else if (ext)              onhook_ticks = CNT_W'(ONHOOK_E_MS * 1000 / TICK_US);
    else                       onhook_ticks = '0;
  endfunction

  // magnitude of a two's complement byte, -128 gives 0x80
  function automatic logic [7:0] mag8(input logic [7:0] v);
    mag8 = v[7] ? 8'(~v + 8'h01) : v;
  endfunction

endpackage

/* verilog/hthr_thresh.sv */
// line status capture, low-voltage forcing and threshold comparator
// assumes the converter codes change slowly relative to the clock
`timescale 1ns/1ps
`default_nettype none
module hthr_thresh (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] loop_current_raw_i,
  input  wire logic [7:0] line_voltage_raw_i,
  hthr_if.thr             bus
);
  logic [7:0] lc_s1_ff, lc_s2_ff, lv_s1_ff, lv_s2_ff;
  logic [7:0] lc_ff, nxt_lc, lv_ff, nxt_lv;
  logic       cond_ff, nxt_cond, cross_ff, nxt_cross, rev_ff, nxt_rev;
  logic [7:0] sel_mag;

  // two-stage synchronisers on the converter codes
  always_ff @(posedge clk_i) begin
    lc_s1_ff <= loop_current_raw_i;
    lc_s2_ff <= lc_s1_ff;
    lv_s1_ff <= line_voltage_raw_i;
    lv_s2_ff <= lv_s1_ff;
  end

  // forcing, compare and edge detect
  always_comb begin
    nxt_lc = lc_s2_ff;
    nxt_lv = lv_s2_ff;
    if (!bus.force_dis && (hthr_pkg::mag8(lv_s2_ff) <= 8'(hthr_pkg::LV_FORCE_V)))
      nxt_lv = 8'h00; // [RULE_06]
    sel_mag  = bus.src_sel ? hthr_pkg::mag8(lv_ff) : lc_ff; // [RULE_11]
    nxt_cond = bus.polarity ? (sel_mag > bus.threshold)    // [RULE_10]
                            : (sel_mag < bus.threshold);
    nxt_cross = nxt_cond && !cond_ff; // [RULE_08]
    nxt_rev   = nxt_lv[7] ^ lv_ff[7]; // [RULE_12]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lc_ff    <= 8'h00;
      lv_ff    <= 8'h00;
      cond_ff  <= 1'b0;
      cross_ff <= 1'b0;
      rev_ff   <= 1'b0;
    end else begin
      lc_ff    <= nxt_lc;
      lv_ff    <= nxt_lv;
      cond_ff  <= nxt_cond;
      cross_ff <= nxt_cross;
      rev_ff   <= nxt_rev;
    end
  end

  assign bus.loop_current = lc_ff;
  assign bus.line_voltage = lv_ff;
  assign bus.cross_evt    = cross_ff;
  assign bus.rev_evt      = rev_ff;

  // a fresh compare in the chosen sense always raises the crossing pulse in the same cycle
  property p_cross_sense;
    @(posedge clk_i) disable iff (rst_i)
    $rose(cond_ff) |-> cross_ff && !$past(cond_ff);
  endproperty
  a_cross_sense: assert property (p_cross_sense) else $error("cross event missing"); // [RULE_08]

  property p_force_low;
    @(posedge clk_i) disable iff (rst_i)
    !bus.force_dis |=> (lv_ff == 8'h00) || (hthr_pkg::mag8(lv_ff) > 8'(hthr_pkg::LV_FORCE_V));
  endproperty
  a_force_low: assert property (p_force_low) else $error("low voltage not forced"); // [RULE_06]

  property p_rev_sign;
    @(posedge clk_i) disable iff (rst_i)
    (lv_ff[7] != $past(lv_ff[7])) |-> rev_ff;
  endproperty
  a_rev_sign: assert property (p_rev_sign) else $error("reversal not flagged"); // [RULE_12]
endmodule
`default_nettype wire

/* verilog/hthr_timer.sv */
// tick divider and down counter for off-hook and on-hook timing
// assumes load is a one-cycle pulse from the hook state machine
`timescale 1ns/1ps
`default_nettype none
module hthr_timer #(
  parameter int TICK_CYC = hthr_pkg::TICK_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      load_i,
  input  wire logic [hthr_pkg::CNT_W-1:0] len_i,
  output logic                           done_o
);
  logic [31:0]                div_ff, nxt_div;
  logic [hthr_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic                       busy_ff, nxt_busy;
  logic                       done_ff, nxt_done;
  logic                       tick;

  // tick is a one-cycle enable every TICK_CYC cycles while busy
  assign tick = busy_ff && (div_ff == 32'h0);

  always_comb begin
    nxt_div  = div_ff;
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (load_i) begin
      nxt_div  = 32'(TICK_CYC - 1);
      nxt_cnt  = len_i;
      nxt_busy = (len_i != '0);
      nxt_done = (len_i == '0);
    end else if (busy_ff) begin
      nxt_div = tick ? 32'(TICK_CYC - 1) : div_ff - 32'h1;
      if (tick) begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == 1) begin
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff  <= 32'h0;
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign done_o = done_ff;
endmodule
`default_nettype wire

/* verilog/hthr_top.sv */
// hook timing and line threshold register slice, wishbone slave
// assumes classic single-cycle wishbone on clk_i and a synchronous reset
//
// How it works
// (RULE_01) two-bit code picks off-hook counter length
// (RULE_02) reset code gives 128 ms off-hook count
// (RULE_03) on-hook time runs from request clear
// (RULE_04) speed bits pick fast, 3 ms, 26 ms
// (RULE_05) pole bit selects 5 Hz or 200 Hz
// (RULE_06) small line voltage forced zero unless disabled
// (RULE_07) eight-bit threshold register, read and write
// (RULE_08) crossing the threshold raises an event
// (RULE_09) sticky flag, write zero clears, masked interrupt
// (RULE_10) magnitude compare, polarity picks fall or rise
// (RULE_11) source bit picks current or voltage
// (RULE_12) voltage is signed, top bit shows polarity
// (RULE_13) reserved bits and registers read zero
`timescale 1ns/1ps
`default_nettype none
module hthr_top #(
  parameter int TICK_CYC = hthr_pkg::TICK_CYC
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [hthr_pkg::WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic [7:0]                   loop_current_raw_i,
  input  wire logic [7:0]                   line_voltage_raw_i,
  output logic                              hook_close_o,
  output logic                              offhook_settled_o,
  output logic                              onhook_release_o,
  output logic                              rx_pole_sel_o,
  output logic                              irq_o
);

  // hook sequencer states, gray along idle, seize, held, release
  typedef enum logic [1:0] {
    HTHR_IDLE    = 2'b00,
    HTHR_SEIZE   = 2'b01,
    HTHR_HELD    = 2'b11,
    HTHR_RELEASE = 2'b10
  } hthr_state_t;

  hthr_state_t                st_ff, nxt_st;
  logic        [7:0]          ctrl4_ff, nxt_ctrl4;
  logic        [7:0]          thresh_ff, nxt_thresh;
  logic        [7:0]          thrctl_ff, nxt_thrctl;
  logic        [7:0]          aux_ff, nxt_aux;
  logic        [3:0]          stat_ff, nxt_stat;
  logic        [3:0]          mask_ff, nxt_mask;
  logic                       ack_ff, nxt_ack;
  logic        [31:0]         dat_ff, nxt_dat;
  logic                       req;
  logic                       wr;
  logic        [7:0]          idx;
  logic        [7:0]          wbyte;
  logic        [7:0]          rd_byte;
  logic                       tmr_load;
  logic [hthr_pkg::CNT_W-1:0] tmr_len;
  logic                       tmr_done;
  logic        [3:0]          evt;
  logic                       oh_req;
  logic                       cv_irq;

  hthr_if thr_bus ();

  // comparator and status capture
  hthr_thresh u_thresh (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .loop_current_raw_i (loop_current_raw_i),
    .line_voltage_raw_i (line_voltage_raw_i),
    .bus                (thr_bus.thr)
  );

  // shared tick timer for seize and release phases
  hthr_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (tmr_load),
    .len_i  (tmr_len),
    .done_o (tmr_done)
  );

  // configuration toward the comparator
  assign thr_bus.threshold = thresh_ff;                            // [RULE_07]
  assign thr_bus.src_sel   = thrctl_ff[hthr_pkg::THR_CVS];          // [RULE_11]
  assign thr_bus.polarity  = thrctl_ff[hthr_pkg::THR_CVP];          // [RULE_10]
  assign thr_bus.force_dis = ctrl4_ff[hthr_pkg::CTRL4_LINE_VOLT_FORCE_DISABLE];        // [RULE_06]

  // bus decode, writes land on the edge that sees ack
  assign req   = wb_cyc_i && wb_stb_i;
  assign idx   = wb_adr_i[hthr_pkg::WB_ADR_W-1:2];
  assign wr    = req && wb_we_i && ack_ff && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign oh_req = aux_ff[hthr_pkg::AUX_OH];

  // read mux, unmapped and reserved words read zero
  always_comb begin
    unique case (idx)
      hthr_pkg::IDX_LOOP_CUR:  rd_byte = thr_bus.loop_current;
      hthr_pkg::IDX_LINE_VOLT: rd_byte = thr_bus.line_voltage;       // [RULE_12]
      hthr_pkg::IDX_CTRL4:     rd_byte = ctrl4_ff & hthr_pkg::CTRL4_WMASK; // [RULE_13]
      hthr_pkg::IDX_THRESH:    rd_byte = thresh_ff;                  // [RULE_07]
      hthr_pkg::IDX_THR_CTRL:  rd_byte = thrctl_ff;
      hthr_pkg::IDX_AUX:       rd_byte = aux_ff;
      hthr_pkg::IDX_IRQ_STAT:  rd_byte = {4'h0, stat_ff};
      hthr_pkg::IDX_IRQ_MASK:  rd_byte = {4'h0, mask_ff};
      default:                 rd_byte = 8'h00;                      // [RULE_13]
    endcase
  end

  // bus answer: ack one cycle after request, data beside it
  always_comb begin
    nxt_ack = req && !ack_ff;
    nxt_dat = 32'h0;
    if (req && !wb_we_i && !ack_ff)
      nxt_dat = {24'h000000, rd_byte};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // hook sequencer: seize count, hold, timed release
  always_comb begin
    nxt_st   = st_ff;
    tmr_load = 1'b0;
    tmr_len  = '0;
    evt      = '0;
    unique case (st_ff)
      HTHR_IDLE: begin
        if (oh_req) begin
          nxt_st   = HTHR_SEIZE;
          tmr_load = 1'b1;
          tmr_len  = hthr_pkg::foh_ticks(ctrl4_ff[hthr_pkg::CTRL4_FOH_LSB +: 2]); // [RULE_01]
        end
      end
      HTHR_SEIZE: begin
        if (!oh_req) begin
          nxt_st   = HTHR_RELEASE;                                   // [RULE_03]
          tmr_load = 1'b1;
          tmr_len  = hthr_pkg::onhook_ticks(aux_ff[hthr_pkg::AUX_OHS],
                                            ctrl4_ff[hthr_pkg::CTRL4_ONHOOK_SPEED_EXT],
                                            aux_ff[hthr_pkg::AUX_SQ_LSB +: 2]);
        end else if (tmr_done) begin
          nxt_st = HTHR_HELD;
          evt[hthr_pkg::EVT_SETTLED] = 1'b1;
        end
      end
      HTHR_HELD: begin
        if (!oh_req) begin
          nxt_st   = HTHR_RELEASE;                                   // [RULE_03]
          tmr_load = 1'b1;
          tmr_len  = hthr_pkg::onhook_ticks(aux_ff[hthr_pkg::AUX_OHS],    // [RULE_04]
                                            ctrl4_ff[hthr_pkg::CTRL4_ONHOOK_SPEED_EXT],
                                            aux_ff[hthr_pkg::AUX_SQ_LSB +: 2]);
        end
      end
      HTHR_RELEASE: begin
        if (tmr_done) begin
          nxt_st = HTHR_IDLE;
          evt[hthr_pkg::EVT_ONHOOK] = 1'b1;
        end
      end
    endcase
    evt[hthr_pkg::EVT_CROSS] = thr_bus.cross_evt;                    // [RULE_08]
    evt[hthr_pkg::EVT_REV]   = thr_bus.rev_evt;                      // [RULE_12]
  end

  // register writes, hardware sets win over software clears
  always_comb begin
    nxt_ctrl4  = ctrl4_ff;
    nxt_thresh = thresh_ff;
    nxt_thrctl = thrctl_ff;
    nxt_aux    = aux_ff;
    nxt_mask   = mask_ff;
    nxt_stat   = stat_ff;
    if (wr) begin
      unique case (idx)
        hthr_pkg::IDX_CTRL4:    nxt_ctrl4  = wbyte & hthr_pkg::CTRL4_WMASK; // [RULE_13]
        hthr_pkg::IDX_THRESH:   nxt_thresh = wbyte;                         // [RULE_07]
        hthr_pkg::IDX_THR_CTRL: begin
          nxt_thrctl = (thrctl_ff & ~hthr_pkg::THR_WMASK) | (wbyte & hthr_pkg::THR_WMASK);
          if (!wbyte[hthr_pkg::THR_CVI])
            nxt_thrctl[hthr_pkg::THR_CVI] = 1'b0;                   // [RULE_09]
        end
        hthr_pkg::IDX_AUX:      nxt_aux    = wbyte & hthr_pkg::AUX_WMASK;
        hthr_pkg::IDX_IRQ_STAT: nxt_stat   = stat_ff & ~wbyte[3:0];
        hthr_pkg::IDX_IRQ_MASK: nxt_mask   = wbyte[3:0];
        default:                nxt_ctrl4  = ctrl4_ff;                      // [RULE_13]
      endcase
    end
    if (thr_bus.cross_evt)
      nxt_thrctl[hthr_pkg::THR_CVI] = 1'b1;                          // [RULE_09]
    nxt_stat = nxt_stat | evt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff     <= HTHR_IDLE;
      ctrl4_ff  <= hthr_pkg::CTRL4_RST;                              // [RULE_02]
      thresh_ff <= hthr_pkg::THRESH_RST;
      thrctl_ff <= hthr_pkg::THR_CTRL_RST;
      aux_ff    <= hthr_pkg::AUX_RST;
      stat_ff   <= hthr_pkg::IRQ_RST;
      mask_ff   <= hthr_pkg::IRQ_RST;
    end else begin
      st_ff     <= nxt_st;
      ctrl4_ff  <= nxt_ctrl4;
      thresh_ff <= nxt_thresh;
      thrctl_ff <= nxt_thrctl;
      aux_ff    <= nxt_aux;
      stat_ff   <= nxt_stat;
      mask_ff   <= nxt_mask;
    end
  end

  // outputs and the single level interrupt
  assign cv_irq = thrctl_ff[hthr_pkg::THR_CVI] && thrctl_ff[hthr_pkg::THR_CVM]
                  && aux_ff[hthr_pkg::AUX_GLOBAL_IRQ_ENABLE];                     // [RULE_09]
  assign irq_o             = cv_irq || |(stat_ff & mask_ff);
  assign hook_close_o      = (st_ff != HTHR_IDLE);
  assign offhook_settled_o = (st_ff == HTHR_HELD);
  assign onhook_release_o  = (st_ff == HTHR_RELEASE);
  assign rx_pole_sel_o     = ctrl4_ff[hthr_pkg::CTRL4_RX_POLE_SEL];        // [RULE_05]

  // helper: cycles spent in the current sequencer state
  logic [31:0] phase_cnt_ff;
  logic [hthr_pkg::CNT_W-1:0] seize_len_ff, rel_len_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_cnt_ff <= 32'h0;
      seize_len_ff <= '0;
      rel_len_ff   <= '0;
    end else begin
      phase_cnt_ff <= (nxt_st != st_ff) ? 32'h0 : phase_cnt_ff + 32'h1;
      if (tmr_load && (st_ff == HTHR_IDLE)) seize_len_ff <= tmr_len;
      if (tmr_load && (st_ff != HTHR_IDLE)) rel_len_ff   <= tmr_len;
    end
  end

  property p_foh_reset;
    @(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> ctrl4_ff[6:5] == 2'b01;
  endproperty
  a_foh_reset: assert property (p_foh_reset) else $error("bad off-hook reset code"); // [RULE_02]

  property p_foh_len;
    @(posedge clk_i) disable iff (rst_i)
    (st_ff == HTHR_SEIZE && nxt_st == HTHR_HELD) |->
      (phase_cnt_ff + 32'h2 >= 32'(int'(seize_len_ff) * TICK_CYC)) &&
      (phase_cnt_ff <= 32'(int'(seize_len_ff) * TICK_CYC) + 32'h2);
  endproperty
  a_foh_len: assert property (p_foh_len) else $error("off-hook count length wrong"); // [RULE_01]

  property p_seize_code;
    @(posedge clk_i) disable iff (rst_i)
    (st_ff == HTHR_IDLE && oh_req) |=> seize_len_ff ==
      hthr_pkg::foh_ticks($past(ctrl4_ff[6:5]));
  endproperty
  a_seize_code: assert property (p_seize_code) else $error("seize length not decoded"); // [RULE_01]

  property p_onhook_start;
    @(posedge clk_i) disable iff (rst_i)
    (st_ff == HTHR_HELD && !oh_req) |=> onhook_release_o && hook_close_o;
  endproperty
  a_onhook_start: assert property (p_onhook_start) else $error("release not started"); // [RULE_03]

  property p_onhook_len;
    @(posedge clk_i) disable iff (rst_i)
    (st_ff == HTHR_RELEASE && nxt_st == HTHR_IDLE) |->
      (phase_cnt_ff <= 32'(int'(rel_len_ff) * TICK_CYC) + 32'h2);
  endproperty
  a_onhook_len: assert property (p_onhook_len) else $error("on-hook ramp too long"); // [RULE_04]

  property p_pole;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == hthr_pkg::IDX_CTRL4) |=> rx_pole_sel_o == $past(wb_dat_i[1]);
  endproperty
  a_pole: assert property (p_pole) else $error("pole select not applied"); // [RULE_05]

  property p_thresh_wr;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == hthr_pkg::IDX_THRESH) |=> thresh_ff == $past(wb_dat_i[7:0]);
  endproperty
  a_thresh_wr: assert property (p_thresh_wr) else $error("threshold write lost"); // [RULE_07]

  property p_flag_sticky;
    @(posedge clk_i) disable iff (rst_i)
    thr_bus.cross_evt |=> thrctl_ff[hthr_pkg::THR_CVI] ##1
      (thrctl_ff[hthr_pkg::THR_CVI] || $past(wr && idx == hthr_pkg::IDX_THR_CTRL));
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("crossed flag not held"); // [RULE_09]

  property p_irq_gate;
    @(posedge clk_i) disable iff (rst_i)
    (mask_ff == 4'h0) |-> irq_o == (thrctl_ff[3] && thrctl_ff[1] && aux_ff[2]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong"); // [RULE_09]

  property p_rsvd_zero;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && !ack_ff && idx >= hthr_pkg::IDX_RSVD_LO && idx <= hthr_pkg::IDX_RSVD_HI)
      |=> wb_ack_o && wb_dat_o == 32'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero"); // [RULE_13]

  c_held:    cover property (@(posedge clk_i) disable iff (rst_i) st_ff == HTHR_HELD);
  c_release: cover property (@(posedge clk_i) disable iff (rst_i) $fell(onhook_release_o));
  c_cross:   cover property (@(posedge clk_i) disable iff (rst_i) thr_bus.cross_evt);
  c_irq:     cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule
`default_nettype wire
